//--- hdl/dmsr_regs.vh
// offsets, fields, reset values and command codes of the read path
`ifndef DMSR_REGS_VH
`define DMSR_REGS_VH

// register port offsets
`define DMSR_OFF_MODE 8'h00
`define DMSR_OFF_EXT 8'h04
`define DMSR_OFF_STATE 8'h08
`define DMSR_OFF_SENSOR 8'h0c
`define DMSR_OFF_ARR_ADDR 8'h10
`define DMSR_OFF_ARR_DATA 8'h14
`define DMSR_OFF_STATUS 8'h18

// command codes {ras_n, cas_n, we_n} with chip select low
`define DMSR_CMD_LOAD 3'h0
`define DMSR_CMD_REFRESH 3'h1
`define DMSR_CMD_PRECHARGE 3'h2
`define DMSR_CMD_ACTIVE 3'h3
`define DMSR_CMD_WRITE 3'h4
`define DMSR_CMD_READ 3'h5
`define DMSR_CMD_BURST_STOP 3'h6

// {bank_sel_bit1, bank_sel_bit0} on a configuration load
`define DMSR_BA_MAIN 2'h0
`define DMSR_BA_STATUS 2'h1
`define DMSR_BA_EXT 2'h2

// address bit that carries auto precharge / precharge all
`define DMSR_A_AP 10

// main configuration word fields
`define DMSR_MW_BL_LSB 0
`define DMSR_MW_TYPE 3
`define DMSR_MW_LAT_LSB 4
`define DMSR_LAT2 3'h2
`define DMSR_LAT3 3'h3
`define DMSR_BL2 3'h1
`define DMSR_BL4 3'h2
`define DMSR_BL8 3'h3
`define DMSR_BL16 3'h4
`define DMSR_MODE_RST 7'h32

// extended configuration word fields
`define DMSR_EW_PART_REFRESH_LSB 0
`define DMSR_EW_TEMP_COMP_LSB 3
`define DMSR_EW_DS_LSB 5
`define DMSR_EXT_RST 7'h00
`define DMSR_PART_REFRESH_FULL 3'h0
`define DMSR_PART_REFRESH_HALF 3'h1
`define DMSR_PART_REFRESH_QUARTER 3'h2
`define DMSR_PART_REFRESH_EIGHTH 3'h5
`define DMSR_PART_REFRESH_SIXTEENTH 3'h6

// status word fields
`define DMSR_SW_MAKER_LSB 0
`define DMSR_SW_REV_LSB 4
`define DMSR_SW_MULT_LSB 8
`define DMSR_SW_WIDTH 12
`define DMSR_SW_DENS_LSB 13
`define DMSR_SENSOR_RST 4'h1

// state register fields
`define DMSR_ST_OPEN_LSB 0
`define DMSR_ST_ACTIVE 4
`define DMSR_ST_ARMED 5
`define DMSR_ST_RET_LSB 8
`define DMSR_ST_ROWFR_LSB 12

`endif

//--- hdl/dmsr_mem.v
// small array behind the read path, registered read data
`timescale 1ns/10ps
module dmsr_mem #(
  parameter DW = 16,
  parameter AW = 7
) (
  input wire i_mclk,
  input wire i_resetn,
  input wire i_we,
  input wire [AW-1:0] i_waddr,
  input wire [DW-1:0] i_wdata,
  input wire i_re,
  input wire [AW-1:0] i_raddr,
  output reg [DW-1:0] o_rdata
);
  reg [DW-1:0] mem_r [0:(1<<AW)-1];

  always @(posedge i_mclk) begin
    if (i_we) begin
      mem_r[i_waddr] <= i_wdata;
    end
  end

  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= {DW{1'b0}};
    end else if (i_re) begin
      o_rdata <= mem_r[i_raddr];
    end
  end
endmodule

//--- hdl/dmsr_read_path.v
// command decode, configuration words, status readout and read bursts
`timescale 1ns/10ps
`include "dmsr_regs.vh"

module dmsr_read_path #(
  parameter ADDR_W = 13,
  parameter COL_W = 5,
  parameter [3:0] MAKER_ID = 4'h3,
  parameter [3:0] REV_ID = 4'h1,
  parameter WIDTH_TYPE = 1'b0,
  parameter [2:0] DENSITY = 3'h2
) (
  input wire i_mclk,
  input wire i_resetn,
  input wire i_ck,
  input wire i_cs_n,
  input wire i_ras_n,
  input wire i_cas_n,
  input wire i_we_n,
  input wire [1:0] i_ba,
  input wire [ADDR_W-1:0] i_a,
  input wire [7:0] i_reg_addr,
  input wire [31:0] i_reg_wdata,
  input wire i_reg_wr,
  input wire i_reg_rd,
  output reg [31:0] o_reg_rdata,
  output reg [15:0] o_dq,
  output reg o_dq_oe_n,
  output reg o_dqs,
  output reg o_dqs_oe_n
);
  // maker and revision defaults above are arbitrary values
  localparam DQ_W = 16;
  localparam PW = ADDR_W + 7;
  localparam MAW = COL_W + 2;
  localparam ENT = COL_W + 8;
  localparam [1:0] K_RD = 2'h0;
  localparam [1:0] K_STOP = 2'h1;
  localparam [1:0] K_PRE = 2'h2;
  localparam [2:0] S_IDLE = 3'h1;
  localparam [2:0] S_PREAMB = 3'h2;
  localparam [2:0] S_DATA = 3'h4;
  localparam [1:0] SRC_MEM = 2'h0;
  localparam [1:0] SRC_STAT = 2'h1;
  localparam [1:0] SRC_ZERO = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and link clock edges
  wire [PW-1:0] pin_in = {i_ck, i_cs_n, i_ras_n, i_cas_n, i_we_n, i_ba, i_a};
  reg [PW-1:0] meta_r;
  reg [PW-1:0] sync_r;
  reg ck_last_r;
  reg hcs_n_r;
  reg [2:0] hcmd_r;
  reg [1:0] hba_r;
  reg [ADDR_W-1:0] ha_r;

  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_r <= {PW{1'b1}};
      sync_r <= {PW{1'b1}};
      ck_last_r <= 1'b1; // idle level, so no false link edge after reset
    end else begin
      meta_r <= pin_in;
      sync_r <= meta_r;
      ck_last_r <= sync_r[PW-1];
    end
  end

  wire ck_rise = sync_r[PW-1] & ~ck_last_r;
  wire ck_fall = ~sync_r[PW-1] & ck_last_r;

  // command pins are caught mid-cycle, where they are stable, and used at the next rise
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      hcs_n_r <= 1'b1;
      hcmd_r <= 3'h7;
      hba_r <= 2'h0;
      ha_r <= {ADDR_W{1'b0}};
    end else if (ck_fall) begin
      hcs_n_r <= sync_r[PW-2];
      hcmd_r <= sync_r[PW-3:PW-5];
      hba_r <= sync_r[ADDR_W+1:ADDR_W];
      ha_r <= sync_r[ADDR_W-1:0];
    end
  end

  wire is_cmd = ck_rise & ~hcs_n_r;
  wire is_load = is_cmd & (hcmd_r == `DMSR_CMD_LOAD);
  wire is_act = is_cmd & (hcmd_r == `DMSR_CMD_ACTIVE);
  wire is_pre = is_cmd & (hcmd_r == `DMSR_CMD_PRECHARGE);
  wire is_rd = is_cmd & (hcmd_r == `DMSR_CMD_READ);
  wire is_wr = is_cmd & (hcmd_r == `DMSR_CMD_WRITE);
  wire is_bst = is_cmd & (hcmd_r == `DMSR_CMD_BURST_STOP);

  ////////////////////////////////////////////////////////////////////////////
  // configuration words and bank state
  reg [6:0] mode_r;
  reg mode_hi_r;
  reg [6:0] ext_r;
  reg armed_r;
  reg [3:0] open_r;
  reg [3:0] sens_r;
  wire close_ap;
  wire [1:0] close_bank;

  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      mode_r <= `DMSR_MODE_RST;
      mode_hi_r <= 1'b0;
      ext_r <= `DMSR_EXT_RST;
      armed_r <= 1'b0;
    end else if (is_load) begin
      case (hba_r)
        `DMSR_BA_MAIN: begin
          mode_r <= ha_r[6:0];
          mode_hi_r <= |ha_r[ADDR_W-1:7];
        end
        `DMSR_BA_EXT: ext_r <= ha_r[6:0];
        `DMSR_BA_STATUS: armed_r <= 1'b1;
        default: armed_r <= armed_r;
      endcase
    end else if (is_rd) begin
      armed_r <= 1'b0;
    end
  end

  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      open_r <= 4'h0;
    end else begin
      if (close_ap) begin
        open_r[close_bank] <= 1'b0;
      end
      if (is_act) begin
        open_r[hba_r] <= 1'b1;
      end else if (is_pre & ha_r[`DMSR_A_AP]) begin
        open_r <= 4'h0;
      end else if (is_pre) begin
        open_r[hba_r] <= 1'b0;
      end
    end
  end

  // refresh compensation bits stay in ext_r and steer nothing
  wire [2:0] partial_refresh_select = ext_r[`DMSR_EW_PART_REFRESH_LSB +: 3];
  reg [3:0] ret_banks;
  reg [1:0] row_frac;

  always @* begin
    row_frac = 2'h0;
    case (partial_refresh_select)
      `DMSR_PART_REFRESH_FULL: ret_banks = 4'hf;
      `DMSR_PART_REFRESH_HALF: ret_banks = 4'h3;
      `DMSR_PART_REFRESH_QUARTER: ret_banks = 4'h1;
      `DMSR_PART_REFRESH_EIGHTH: begin
        ret_banks = 4'h1;
        row_frac = 2'h1;
      end
      `DMSR_PART_REFRESH_SIXTEENTH: begin
        ret_banks = 4'h1;
        row_frac = 2'h2;
      end
      default: ret_banks = 4'hf;
    endcase
  end

  wire [DQ_W-1:0] status_word = {DENSITY, WIDTH_TYPE, sens_r, REV_ID, MAKER_ID};

  ////////////////////////////////////////////////////////////////////////////
  // latency pipeline: {col, prechg_all, status, ap, bank, kind, valid}
  reg [ENT-1:0] st0_r;
  reg [ENT-1:0] st1_r;
  wire ent_v = is_rd | is_wr | is_bst | is_pre;
  wire [1:0] ent_k = is_rd ? K_RD : (is_pre ? K_PRE : K_STOP);
  wire [ENT-1:0] ent_new = ent_v ? {ha_r[COL_W-1:0], ha_r[`DMSR_A_AP], armed_r,
    ha_r[`DMSR_A_AP], hba_r, ent_k, 1'b1} : {ENT{1'b0}};

  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      st0_r <= {ENT{1'b0}};
      st1_r <= {ENT{1'b0}};
    end else if (ck_rise) begin
      st0_r <= ent_new;
      st1_r <= st0_r;
    end
  end

  // bursts and their stops take effect at the programmed latency of 2 or 3; any other latency code acts as 3
  wire lat2 = (mode_r[`DMSR_MW_LAT_LSB +: 3] == `DMSR_LAT2);
  wire [ENT-1:0] eff = lat2 ? st0_r : st1_r;
  wire [ENT-1:0] prq = lat2 ? ent_new : st0_r;
  wire eff_rd = eff[0] & (eff[2:1] == K_RD);
  wire prq_rd = prq[0] & (prq[2:1] == K_RD);

  ////////////////////////////////////////////////////////////////////////////
  // burst engine
  reg [2:0] state_r;
  reg [1:0] b_bank_r;
  reg [COL_W-1:0] b_col_r;
  reg [COL_W-1:0] b_idx_r;
  reg [4:0] b_rem_r;
  reg [2:0] b_lg_r;
  reg b_ilv_r;
  reg b_ap_r;
  reg b_status_readout_r;
  reg q_drv_r;
  reg q_dqs_r;
  reg q_dqs_oe_r;
  reg [1:0] q_src_r;
  wire [DQ_W-1:0] mem_q;
  reg [MAW-1:0] rd_addr;
  reg rd_en;
  reg [2:0] new_lg;

  always @* begin
    case (mode_r[`DMSR_MW_BL_LSB +: 3])
      `DMSR_BL2: new_lg = 3'h1;
      `DMSR_BL4: new_lg = 3'h2;
      `DMSR_BL8: new_lg = 3'h3;
      `DMSR_BL16: new_lg = 3'h4;
      default: new_lg = 3'h2;
    endcase
    if (eff[6]) begin
      new_lg = 3'h1;
    end
  end

  wire [COL_W-1:0] mask;
  genvar gi;
  generate
    for (gi = 0; gi < COL_W; gi = gi + 1) begin : g_mask
      localparam [2:0] BITN = gi;
      assign mask[gi] = (BITN < b_lg_r);
    end
  endgenerate

  // wrap inside the aligned block of burst length
  wire [COL_W-1:0] seq_c = (b_col_r & ~mask) | ((b_col_r + b_idx_r) & mask);
  wire [COL_W-1:0] ilv_c = (b_col_r & ~mask) | ((b_col_r ^ b_idx_r) & mask);
  wire [COL_W-1:0] col_now = b_ilv_r ? ilv_c : seq_c;
  wire in_data = state_r[2];
  wire more = in_data & (b_rem_r != 5'h0);
  wire pre_hit = eff[0] & (eff[2:1] == K_PRE) & (eff[7] | (eff[4:3] == b_bank_r));
  wire eff_stop = in_data & eff[0] & ((eff[2:1] == K_STOP) | (pre_hit & ~b_ap_r));
  assign close_ap = ck_rise & in_data & b_ap_r & (eff_rd | eff_stop | ~more);
  assign close_bank = b_bank_r;

  always @* begin
    rd_en = (ck_rise | ck_fall) & (eff_rd | more);
    rd_addr = (ck_rise & eff_rd) ? {eff[4:3], eff[ENT-1:8]} : {b_bank_r, col_now};
  end

  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_r <= S_IDLE;
      b_bank_r <= 2'h0;
      b_col_r <= {COL_W{1'b0}};
      b_idx_r <= {COL_W{1'b0}};
      b_rem_r <= 5'h0;
      b_lg_r <= 3'h1;
      b_ilv_r <= 1'b0;
      b_ap_r <= 1'b0;
      b_status_readout_r <= 1'b0;
      q_drv_r <= 1'b0;
      q_dqs_r <= 1'b0;
      q_dqs_oe_r <= 1'b0;
      q_src_r <= SRC_MEM;
    end else if (ck_rise) begin
      if (eff_rd) begin
        state_r <= S_DATA;
        b_bank_r <= eff[4:3];
        b_col_r <= eff[ENT-1:8];
        b_idx_r <= {{(COL_W-1){1'b0}}, 1'b1};
        b_rem_r <= (5'h1 << new_lg) - 5'h1; // elements still due after the first
        b_lg_r <= new_lg;
        b_ilv_r <= mode_r[`DMSR_MW_TYPE];
        b_ap_r <= eff[5] & ~eff[6];
        b_status_readout_r <= eff[6];
        q_drv_r <= 1'b1;
        q_dqs_r <= 1'b1;
        q_dqs_oe_r <= 1'b1;
        q_src_r <= eff[6] ? SRC_STAT : SRC_MEM;
      end else if (more & ~eff_stop) begin
        b_idx_r <= b_idx_r + {{(COL_W-1){1'b0}}, 1'b1};
        b_rem_r <= b_rem_r - 5'h1;
        q_drv_r <= 1'b1;
        q_dqs_r <= 1'b1;
        q_src_r <= b_status_readout_r ? SRC_ZERO : SRC_MEM;
      end else if (prq_rd) begin
        state_r <= S_PREAMB;
        q_drv_r <= 1'b0;
        q_dqs_r <= 1'b0;
        q_dqs_oe_r <= 1'b1;
      end else begin
        state_r <= S_IDLE;
        q_drv_r <= 1'b0;
        q_dqs_r <= 1'b0;
        q_dqs_oe_r <= 1'b0;
      end
    end else if (ck_fall) begin
      case (state_r)
        S_DATA: begin
          if (more) begin
            b_idx_r <= b_idx_r + {{(COL_W-1){1'b0}}, 1'b1};
            b_rem_r <= b_rem_r - 5'h1;
            q_src_r <= b_status_readout_r ? SRC_ZERO : SRC_MEM;
          end
          q_dqs_r <= 1'b0;
        end
        S_PREAMB: q_dqs_r <= 1'b0;
        default: q_dqs_r <= 1'b0;
      endcase
    end
  end

  reg [MAW-1:0] arr_addr_r;
  wire arr_we = i_reg_wr & (i_reg_addr == `DMSR_OFF_ARR_DATA);

  dmsr_mem #(
    .DW(DQ_W),
    .AW(MAW)
  ) u_mem (
    .i_mclk(i_mclk),
    .i_resetn(i_resetn),
    .i_we(arr_we),
    .i_waddr(arr_addr_r),
    .i_wdata(i_reg_wdata[DQ_W-1:0]),
    .i_re(rd_en),
    .i_raddr(rd_addr),
    .o_rdata(mem_q)
  );

  // mem_q and q_* are both one cycle behind the link edge, so they line up here
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_dq <= 16'h0000;
      o_dq_oe_n <= 1'b1;
      o_dqs <= 1'b0;
      o_dqs_oe_n <= 1'b1;
    end else begin
      if (!q_drv_r) begin
        o_dq <= 16'h0000;
      end else if (q_src_r == SRC_STAT) begin
        o_dq <= status_word;
      end else if (q_src_r == SRC_ZERO) begin
        o_dq <= 16'h0000;
      end else begin
        o_dq <= mem_q;
      end
      o_dq_oe_n <= ~q_drv_r;
      o_dqs <= q_dqs_r;
      o_dqs_oe_n <= ~q_dqs_oe_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register port
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      sens_r <= `DMSR_SENSOR_RST;
      arr_addr_r <= {MAW{1'b0}};
    end else if (i_reg_wr) begin
      case (i_reg_addr)
        `DMSR_OFF_SENSOR: sens_r <= i_reg_wdata[3:0];
        `DMSR_OFF_ARR_ADDR: arr_addr_r <= i_reg_wdata[MAW-1:0];
        `DMSR_OFF_ARR_DATA: arr_addr_r <= arr_addr_r + {{(MAW-1){1'b0}}, 1'b1};
        default: arr_addr_r <= arr_addr_r;
      endcase
    end
  end

  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_reg_rdata <= 32'h00000000;
    end else if (i_reg_rd) begin
      case (i_reg_addr)
        `DMSR_OFF_MODE: o_reg_rdata <= {mode_hi_r, 24'h000000, mode_r};
        `DMSR_OFF_EXT: o_reg_rdata <= {25'h0000000, ext_r};
        `DMSR_OFF_STATE: o_reg_rdata <= {18'h00000, row_frac, ret_banks,
          2'h0, armed_r, in_data, open_r};
        `DMSR_OFF_SENSOR: o_reg_rdata <= {28'h0000000, sens_r};
        `DMSR_OFF_ARR_ADDR: o_reg_rdata <= {{(32-MAW){1'b0}}, arr_addr_r};
        `DMSR_OFF_STATUS: o_reg_rdata <= {16'h0000, status_word};
        default: o_reg_rdata <= 32'h00000000;
      endcase
    end else begin
      o_reg_rdata <= 32'h00000000;
    end
  end
endmodule

//--- bench/dmsr_ctrl_model.sv
// controller side model: link clock and command pins
`timescale 1ns/10ps
module dmsr_ctrl_model #(
  parameter ADDR_W = 13
) (
  output logic o_ck,
  output logic o_cs_n,
  output logic o_ras_n,
  output logic o_cas_n,
  output logic o_we_n,
  output logic [1:0] o_ba,
  output logic [ADDR_W-1:0] o_a
);
  initial begin
    o_ck = 1'b1;
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'hf;
    o_ba = 2'h0;
    o_a = '0;
  end
  // clock stands high between commands; pins sampled at the fall
  task automatic tick();
    #80 o_ck = 1'b0;
    #80 o_ck = 1'b1;
  endtask
  task automatic cmd(input logic [2:0] c, input logic [1:0] ba,
                     input logic [ADDR_W-1:0] a, input int nops);
    {o_cs_n, o_ras_n, o_cas_n, o_we_n} = {1'b0, c};
    o_ba = ba;
    o_a = a;
    tick();
    // deselect fill; inverted lines so nothing stale looks valid
    repeat (nops) begin
      {o_cs_n, o_ras_n, o_cas_n, o_we_n} = 4'hf;
      o_ba = ~o_ba;
      o_a = ~o_a;
      tick();
    end
  endtask
endmodule

//--- bench/dmsr_read_path_asserts.sv
// checker for the read path pins and register port
`timescale 1ns/10ps
`include "dmsr_regs.vh"
module dmsr_read_path_asserts (
  input wire i_mclk,
  input wire i_resetn,
  input wire [7:0] i_reg_addr,
  input wire [31:0] i_reg_wdata,
  input wire i_reg_wr,
  input wire i_reg_rd,
  input wire [31:0] o_reg_rdata,
  input wire [15:0] o_dq,
  input wire o_dq_oe_n,
  input wire o_dqs,
  input wire o_dqs_oe_n
);
  reg [3:0] sens_r;
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) sens_r <= 4'h1;
    else if (i_reg_wr && i_reg_addr == `DMSR_OFF_SENSOR) sens_r <= i_reg_wdata[3:0];
  end
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  dq_quiet_a: assert property (o_dq_oe_n |-> o_dq == 16'h0000)
    else $error("data lines not quiet while released");
  dqs_quiet_a: assert property (o_dqs_oe_n |-> !o_dqs)
    else $error("strobe high while released");
  data_strobe_a: assert property (!o_dq_oe_n |-> !o_dqs_oe_n)
    else $error("data driven without strobe");
  preamble_len_a: assert property ($fell(o_dqs_oe_n) |->
    (!o_dqs && o_dq_oe_n) [*6] ##[1:4] !o_dq_oe_n)
    else $error("preamble not one link period low");
  first_elem_a: assert property ($fell(o_dq_oe_n) |-> o_dqs && !o_dqs_oe_n)
    else $error("first element not on strobe high");
  elem_hold_a: assert property (!o_dq_oe_n && $changed(o_dqs) |=> $stable(o_dqs) [*2])
    else $error("element shorter than half period");
  post_release_a: assert property ($rose(o_dq_oe_n) |-> o_dqs_oe_n && !$past(o_dqs))
    else $error("release without low postamble");
  rdata_idle_a: assert property (!$past(i_reg_rd) |-> o_reg_rdata == 32'h0)
    else $error("read data outside its cycle");
  status_mult_a: assert property (i_reg_rd && i_reg_addr == `DMSR_OFF_STATUS |=>
    o_reg_rdata[11:8] == sens_r)
    else $error("status multiplier differs from sensor");
  cover property ($fell(o_dqs_oe_n));
  cover property ($rose(o_dq_oe_n));
  cover property (i_reg_wr ##1 i_reg_rd && i_reg_addr == `DMSR_OFF_STATUS);
endmodule
bind dmsr_read_path dmsr_read_path_asserts u_chk (
  .i_mclk(i_mclk), .i_resetn(i_resetn), .i_reg_addr(i_reg_addr),
  .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
  .o_reg_rdata(o_reg_rdata), .o_dq(o_dq), .o_dq_oe_n(o_dq_oe_n),
  .o_dqs(o_dqs), .o_dqs_oe_n(o_dqs_oe_n)
);

//--- bench/dmsr_read_path_test.sv
// self-checking bench for the read path
`timescale 1ns/10ps
`include "dmsr_regs.vh"
module dmsr_read_path_test;
  localparam [3:0] MK = 4'h6; // arbitrary maker value
  localparam [3:0] RV = 4'h2; // arbitrary revision value
  localparam [2:0] DN = 3'h5;
  localparam logic [13:0] ROWS [7] = '{{7'h31, 2'd0, 5'd1}, {7'h22, 2'd1, 5'd6},
    {7'h33, 2'd2, 5'd13}, {7'h3b, 2'd2, 5'd13}, {7'h24, 2'd3, 5'd21},
    {7'h2c, 2'd0, 5'd7}, {7'h3a, 2'd1, 5'd3}};
  localparam logic [8:0] EXT_TAB [5] = '{{3'h0, 2'h0, 4'hf}, {3'h1, 2'h0, 4'h3},
    {3'h2, 2'h0, 4'h1}, {3'h5, 2'h1, 4'h1}, {3'h6, 2'h2, 4'h1}};
  localparam logic [31:0] SW = {16'h0, DN, 1'b1, 4'h5, RV, MK};
  logic i_mclk = 0, i_resetn = 0, i_reg_wr = 0, i_reg_rd = 0, pdqs = 0;
  logic [7:0] i_reg_addr = 8'h00;
  logic [31:0] i_reg_wdata = 32'h0;
  wire i_ck, i_cs_n, i_ras_n, i_cas_n, i_we_n, o_dq_oe_n, o_dqs, o_dqs_oe_n;
  wire [1:0] i_ba;
  wire [12:0] i_a;
  wire [31:0] o_reg_rdata;
  wire [15:0] o_dq;
  int err_total = 0, checks = 0, bl;
  logic [15:0] got[$], exq[$];
  logic [6:0] m;
  logic [1:0] b;
  logic [4:0] st;
  time t_read, t_first;
  always #10 i_mclk = ~i_mclk;
  dmsr_ctrl_model lnk (.o_ck(i_ck), .o_cs_n(i_cs_n), .o_ras_n(i_ras_n),
    .o_cas_n(i_cas_n), .o_we_n(i_we_n), .o_ba(i_ba), .o_a(i_a));
  dmsr_read_path #(.MAKER_ID(MK), .REV_ID(RV), .WIDTH_TYPE(1'b1), .DENSITY(DN)) dut (
    .i_mclk(i_mclk), .i_resetn(i_resetn), .i_ck(i_ck), .i_cs_n(i_cs_n),
    .i_ras_n(i_ras_n), .i_cas_n(i_cas_n), .i_we_n(i_we_n), .i_ba(i_ba), .i_a(i_a),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .i_reg_wr(i_reg_wr),
    .i_reg_rd(i_reg_rd), .o_reg_rdata(o_reg_rdata), .o_dq(o_dq),
    .o_dq_oe_n(o_dq_oe_n), .o_dqs(o_dqs), .o_dqs_oe_n(o_dqs_oe_n));
  // each strobe edge while driving marks one element
  always @(posedge i_mclk) begin
    if (o_dq_oe_n === 1'b0 && o_dqs !== pdqs) begin
      if (got.size() == 0) t_first = $time;
      got.push_back(o_dq);
    end
    pdqs <= o_dqs;
  end
  task automatic close_out();
    $display("mismatches %0d comparisons %0d", err_total, checks);
    if (err_total == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("FAIL t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic r, input logic [7:0] ad, input logic [31:0] d);
    @(posedge i_mclk);
    i_reg_wr <= w;
    i_reg_rd <= r;
    i_reg_addr <= ad;
    i_reg_wdata <= d;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    bus(1, 0, ad, d);
    bus(0, 0, ad, d);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] e);
    bus(0, 1, ad, 32'h0);
    bus(0, 0, ad, 32'h0);
    #1 cmp(o_reg_rdata, e);
  endtask
  task automatic expb(input int bk, input int s, input int n_bl, input int il, input int n);
    int c;
    for (int i = 0; i < n; i++) begin
      c = il ? (s ^ i) : ((s & ~(n_bl - 1)) | ((s + i) & (n_bl - 1)));
      exq.push_back(16'(32'hc000 | (bk * 32 + (c & 31))));
    end
  endtask
  task automatic drain();
    int k;
    for (k = 0; k < 60 && !(o_dq_oe_n === 1'b1 && o_dqs_oe_n === 1'b1); k++) @(posedge i_mclk);
    if (k == 60) begin
      err_total++;
      close_out();
    end
    repeat (2) @(posedge i_mclk);
    cmp(got.size(), exq.size());
    foreach (exq[i]) if (i < got.size()) cmp(got[i], exq[i]);
    got = {};
    exq = {};
  endtask
  initial begin
    #500000;
    err_total++;
    close_out();
  end
  initial begin
    repeat (10) @(posedge i_mclk);
    i_resetn <= 1;
    rd(`DMSR_OFF_MODE, 32'h32);
    rd(`DMSR_OFF_EXT, 32'h0);
    rd(`DMSR_OFF_SENSOR, 32'h1);
    rd(8'h1c, 32'h0);
    wr(`DMSR_OFF_MODE, 32'h0);
    rd(`DMSR_OFF_MODE, 32'h32);
    wr(`DMSR_OFF_ARR_ADDR, 32'h0);
    for (int i = 0; i < 128; i++) bus(1, 0, `DMSR_OFF_ARR_DATA, 32'hc000 | i);
    bus(0, 0, 8'h0, 32'h0);
    lnk.tick();
    foreach (ROWS[r]) begin
      {m, b, st} = ROWS[r];
      bl = 2 << (m[2:0] - 1);
      lnk.cmd(`DMSR_CMD_LOAD, `DMSR_BA_MAIN, {6'h0, m}, 2);
      rd(`DMSR_OFF_MODE, {25'h0, m});
      lnk.cmd(`DMSR_CMD_ACTIVE, b, 13'h0, 2);
      t_read = $time + 160;
      lnk.cmd(`DMSR_CMD_READ, b, {8'h0, st}, bl / 2 + 3);
      expb(b, st, bl, m[3], bl);
      drain();
      cmp((t_first - t_read) / 160, m[6:4] - 1);
      lnk.cmd(`DMSR_CMD_PRECHARGE, b, 13'h0, 3);
    end
    lnk.cmd(`DMSR_CMD_LOAD, `DMSR_BA_MAIN, 13'h32, 2);
    lnk.cmd(`DMSR_CMD_ACTIVE, 2'h0, 13'h0, 2);
    lnk.cmd(`DMSR_CMD_READ, 2'h0, 13'h0, 1);
    lnk.cmd(`DMSR_CMD_READ, 2'h0, 13'h8, 5);
    expb(0, 0, 4, 0, 4);
    expb(0, 8, 4, 0, 4);
    drain();
    lnk.cmd(`DMSR_CMD_PRECHARGE, 2'h0, 13'h400, 3);
    lnk.cmd(`DMSR_CMD_LOAD, `DMSR_BA_MAIN, 13'h33, 2);
    lnk.cmd(`DMSR_CMD_ACTIVE, 2'h0, 13'h0, 2);
    lnk.cmd(`DMSR_CMD_READ, 2'h0, 13'h0, 0);
    lnk.cmd(`DMSR_CMD_READ, 2'h0, 13'h10, 7);
    expb(0, 0, 8, 0, 2);
    expb(0, 16, 8, 0, 8);
    drain();
    lnk.cmd(`DMSR_CMD_READ, 2'h0, 13'h0, 1);
    lnk.cmd(`DMSR_CMD_BURST_STOP, 2'h0, 13'h0, 6);
    expb(0, 0, 8, 0, 4);
    drain();
    rd(`DMSR_OFF_STATE, 32'hf01);
    lnk.cmd(`DMSR_CMD_READ, 2'h0, 13'h4, 0);
    lnk.cmd(`DMSR_CMD_PRECHARGE, 2'h0, 13'h0, 6);
    expb(0, 4, 8, 0, 2);
    drain();
    rd(`DMSR_OFF_STATE, 32'hf00);
    lnk.cmd(`DMSR_CMD_ACTIVE, 2'h0, 13'h0, 2);
    lnk.cmd(`DMSR_CMD_READ, 2'h0, 13'h402, 0);
    lnk.cmd(`DMSR_CMD_PRECHARGE, 2'h0, 13'h0, 6);
    expb(0, 2, 8, 0, 8);
    drain();
    rd(`DMSR_OFF_STATE, 32'hf00);
    // no precharge here: only the auto precharge can close bank 1
    lnk.cmd(`DMSR_CMD_ACTIVE, 2'h1, 13'h0, 2);
    lnk.cmd(`DMSR_CMD_READ, 2'h1, 13'h405, 7);
    expb(1, 5, 8, 0, 8);
    drain();
    rd(`DMSR_OFF_STATE, 32'hf00);
    lnk.cmd(`DMSR_CMD_LOAD, `DMSR_BA_MAIN, 13'hb3, 2);
    rd(`DMSR_OFF_MODE, 32'h80000033);
    bus(1, 0, `DMSR_OFF_SENSOR, 32'h5);
    rd(`DMSR_OFF_STATUS, SW);
    lnk.cmd(`DMSR_CMD_LOAD, `DMSR_BA_STATUS, 13'h0, 3);
    lnk.cmd(`DMSR_CMD_READ, 2'h0, 13'h0, 5);
    exq.push_back(SW[15:0]);
    exq.push_back(16'h0);
    drain();
    foreach (EXT_TAB[e]) begin
      lnk.cmd(`DMSR_CMD_LOAD, `DMSR_BA_EXT, {6'h0, 4'h7, EXT_TAB[e][8:6]}, 2);
      rd(`DMSR_OFF_EXT, {25'h0, 4'h7, EXT_TAB[e][8:6]});
      rd(`DMSR_OFF_STATE, {18'h0, EXT_TAB[e][5:0], 8'h0});
    end
    rd(`DMSR_OFF_STATUS, SW);
    i_resetn <= 0;
    repeat (3) @(posedge i_mclk);
    i_resetn <= 1;
    rd(`DMSR_OFF_MODE, 32'h32);
    rd(`DMSR_OFF_EXT, 32'h0);
    close_out();
  end
endmodule
